// ==== rtl/afsp_pkg.sv ====
// package: constants, types and helpers for the dsp serial port framing block
package afsp_pkg;

  // ==========================================================
  // word and field layout of one 64-bit sub-frame
  // ==========================================================
  localparam int AFSP_WORD_W = 64;                 // bits per sub-frame
  localparam int AFSP_ATT_W = 5;                   // attenuation width per channel
  localparam int AFSP_ATT_L_MSB = 13;              // sub-frame bit 51, msb first
  localparam int AFSP_ATT_R_MSB = 8;               // sub-frame bit 56
  localparam int AFSP_GPO_BIT = 2;                 // sub-frame bit 62, second digital out
  localparam logic [5:0] AFSP_SUB_LAST = 6'h3F;    // last bit of a sub-frame

  // ==========================================================
  // frame sizes, stored as last bit index
  // ==========================================================
  localparam logic [7:0] AFSP_LAST_64 = 8'h3F;     // 64-bit frame
  localparam logic [7:0] AFSP_LAST_128 = 8'h7F;    // 128-bit frame
  localparam logic [7:0] AFSP_LAST_256 = 8'hFF;    // 256-bit frame
  localparam logic [7:0] AFSP_LR_LAST = 8'h1F;     // last bit of left word, alt sync
  localparam logic [11:0] AFSP_MCLK_FS = 12'h100;  // master clock per sample, fixed mode

  // ==========================================================
  // sample-rate dividers, indexed by the three rate straps
  // ==========================================================
  localparam logic [11:0] AFSP_RATE_N [8] = '{12'h100, 12'h180, 12'h200, 12'h280,
                                              12'h300, 12'h400, 12'h500, 12'h600};

  // ==========================================================
  // status codes and reset values
  // ==========================================================
  localparam logic [3:0] AFSP_ERR_BCLK_RANGE = 4'h3; // bit clock out of range
  localparam logic [4:0] AFSP_ATT_RST = 5'h00;       // no attenuation after reset

  // link states, gray along reset -> hunt -> run -> off
  typedef enum logic [1:0] {
    AFSP_LS_RESET = 2'b00,
    AFSP_LS_HUNT = 2'b01,
    AFSP_LS_RUN = 2'b11,
    AFSP_LS_OFF = 2'b10
  } afsp_link_e;

  // divider N from the rate straps
  function automatic logic [11:0] afsp_rate_n(input logic [2:0] rate);
    return AFSP_RATE_N[rate];
  endfunction

  // master clocks per bit: N over bits per frame
  function automatic logic [7:0] afsp_bit_period(input logic [2:0] rate, input logic big);
    logic [11:0] n;
    n = afsp_rate_n(rate);
    return big ? n[11:4] >> 3 : n[11:4] >> 2;
  endfunction

endpackage

// ==== rtl/afsp_stream_if.sv ====
// interface: valid/ready carrier for received sub-frame words
`timescale 1ns/10ps
interface afsp_stream_if;
  import afsp_pkg::*;
  logic valid;                         // word offered
  logic ready;                         // word taken
  logic [AFSP_WORD_W-1:0] data;        // sub-frame, first bit in msb
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/afsp_buf2.sv ====
// module: two-entry word buffer between framer and receiver
`timescale 1ns/10ps
module afsp_buf2 import afsp_pkg::*; (
  // clock and control
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // streams
  afsp_stream_if.snk wr,
  afsp_stream_if.src rd
);
  // ==========================================================
  // storage and pointers
  // ==========================================================
  logic [AFSP_WORD_W-1:0] mem_q [2];   // two flop entries
  logic [AFSP_WORD_W-1:0] mem_d [2];
  logic wp_q, wp_d, rp_q, rp_d;        // write and read index
  logic [1:0] cnt_q, cnt_d;            // fill level
  logic push, pop;

  assign wr.ready = (cnt_q != 2'h2);   // honest full
  assign rd.valid = (cnt_q != 2'h0);   // honest empty
  assign rd.data = mem_q[rp_q];

  // next-state: push and pop may meet in one cycle
  always_comb begin
    push = wr.valid && wr.ready;
    pop = rd.valid && rd.ready;
    mem_d = mem_q;
    wp_d = wp_q ^ push;
    rp_d = rp_q ^ pop;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    if (push) begin
      mem_d[wp_q] = wr.data;
    end
  end

  // registers only; ce low freezes everything
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (ce) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

  a_buf_no_overfill: assert property (@(posedge clock) disable iff (!rst_b)
    ce && cnt_q == 2'h2 && wr.valid && !rd.ready |=> cnt_q == 2'h2)
    else $error("buffer accepts a word while full");
  a_buf_level_track: assert property (@(posedge clock) disable iff (!rst_b)
    ce && wr.valid && wr.ready && !(rd.valid && rd.ready) |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("buffer level did not rise on push");
endmodule // afsp_buf2

// ==== rtl/afsp_irq.sv ====
// module: status-change interrupt for the split-control mode
`timescale 1ns/10ps
module afsp_irq import afsp_pkg::*; (
  // clock and control
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic enable,
  // status sources
  input wire logic conv_valid,
  input wire logic first_di,
  input wire logic left_clip,
  input wire logic right_clip,
  input wire logic [3:0] err_code,
  // software side
  input wire logic mask_bit,
  input wire logic ctrl_read,
  // result
  output logic pending,
  output logic pin_low
);
  // ==========================================================
  // history and sticky pending
  // ==========================================================
  logic [4:0] hist_q, hist_d;          // valid, first input, clips, err==3
  logic primed_q, primed_d;            // history valid after first sample
  logic pend_q, pend_d;
  logic event_hit;
  logic bad_range;

  // next-state: an event in the release cycle wins
  always_comb begin
    bad_range = (err_code == AFSP_ERR_BCLK_RANGE);
    hist_d = {conv_valid, first_di, left_clip, right_clip, bad_range};
    primed_d = 1'b1;
    event_hit = primed_q && enable && (
      (conv_valid != hist_q[4]) || (first_di != hist_q[3]) ||
      (left_clip && !hist_q[2]) || (right_clip && !hist_q[1]) ||
      (!bad_range && hist_q[0]));
    pend_d = pend_q;
    if (ctrl_read) begin
      pend_d = 1'b0;
    end
    if (event_hit) begin
      pend_d = 1'b1;
    end
    if (!enable) begin
      pend_d = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hist_q <= 5'h00;
      primed_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (ce) begin
      hist_q <= hist_d;
      primed_q <= primed_d;
      pend_q <= pend_d;
    end
  end

  assign pending = pend_q;
  assign pin_low = pend_q && !mask_bit && enable;

  a_irq_mask_gate: assert property (@(posedge clock) disable iff (!rst_b)
    mask_bit |-> !pin_low)
    else $error("interrupt driven while masked");
  a_irq_read_clear: assert property (@(posedge clock) disable iff (!rst_b)
    ce && ctrl_read && !event_hit |=> !pending)
    else $error("interrupt not released by control read");
  a_irq_clip_rise: assert property (@(posedge clock) disable iff (!rst_b)
    ce && enable && primed_q && left_clip && !hist_q[2] |=> pending)
    else $error("clip rise did not raise interrupt");
endmodule // afsp_irq

// ==== rtl/afsp_framer.sv ====
// module: dsp-mode serial port framing, master and slave, with split-mode interrupt
`timescale 1ns/10ps
module afsp_framer import afsp_pkg::*; (
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic POWER_DOWN,
  // mode and configuration straps
  input wire logic MODE_STRAP_ONE,
  input wire logic MODE_STRAP_TWO,
  input wire logic MODE_STRAP_THREE,
  input wire logic MASTER_SELECT_STRAP,
  input wire logic FRAME_SIZE_STRAP_HI,
  input wire logic SLOT_SELECT_STRAP_LO,
  input wire logic RATE_STRAP_A,
  input wire logic RATE_STRAP_B,
  input wire logic RATE_STRAP_C,
  // serial link pins
  input wire logic BIT_CLOCK_IN,
  output logic BIT_CLOCK_OUT,
  output logic BIT_CLOCK_OE,
  input wire logic FRAME_SYNC_IN,
  output logic FRAME_SYNC_OUT,
  output logic FRAME_SYNC_OE,
  input wire logic SERIAL_DATA_IN,
  // general purpose pins
  output logic GP_OUTPUT_PIN,
  input wire logic GP_INPUT_PIN,
  output logic [1:0] GP_INPUT_STATE,
  // received words
  output logic WORD_VALID,
  input wire logic WORD_READY,
  output logic [AFSP_WORD_W-1:0] WORD_DATA,
  output logic WORD_OVERRUN,
  // decoded controls and rate
  output logic [AFSP_ATT_W-1:0] ATTEN_LEFT,
  output logic [AFSP_ATT_W-1:0] ATTEN_RIGHT,
  output logic [11:0] SAMPLE_DIVIDER,
  output logic DSP_SERIAL_MODE,
  output logic SPLIT_CONTROL_MODE,
  // split-mode interrupt
  input wire logic CONVERTER_VALID_FLAG,
  input wire logic FIRST_DIGITAL_INPUT,
  input wire logic LEFT_CLIP_FLAG,
  input wire logic RIGHT_CLIP_FLAG,
  input wire logic [3:0] BIT_CLOCK_ERROR,
  input wire logic INTERRUPT_MASK_BIT,
  input wire logic CONTROL_PORT_READ,
  output logic INTERRUPT_OUT_PIN_OUT,
  output logic INTERRUPT_OUT_PIN_OE,
  output logic INTERRUPT_PENDING
);
  // ==========================================================
  // strap capture
  // ==========================================================
  // straps are caught while reset is held: a rate change needs a reset
  logic [8:0] strap_q, strap_d;        // mode3..1, master, size, slot, rate c..a
  logic mode_dsp, mode_split, is_master, size_hi, slot_lo;
  logic [2:0] rate;

  always_comb begin
    strap_d = {MODE_STRAP_THREE, MODE_STRAP_TWO, MODE_STRAP_ONE, MASTER_SELECT_STRAP,
               FRAME_SIZE_STRAP_HI, SLOT_SELECT_STRAP_LO, RATE_STRAP_C, RATE_STRAP_B,
               RATE_STRAP_A};
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      strap_q <= strap_d;
    end
  end

  assign mode_split = strap_q[8];
  assign mode_dsp = !strap_q[8] && strap_q[7] && !strap_q[6];
  assign is_master = strap_q[5];
  assign size_hi = strap_q[4];
  assign slot_lo = strap_q[3];
  assign rate = {strap_q[0], strap_q[1], strap_q[2]}; // strap a is the msb of the code

  // ==========================================================
  // frame geometry
  // ==========================================================
  logic [7:0] frame_last;              // last bit index of a frame
  logic [1:0] my_slot;                 // our sub-frame within the frame
  logic alt_sync;                      // left/right sync shape
  logic bclk_is_mclk;                  // slave 11: bit clock is the master clock

  // geometry from straps
  always_comb begin
    frame_last = AFSP_LAST_64;
    my_slot = 2'h0;
    alt_sync = 1'b0;
    bclk_is_mclk = 1'b0;
    if (is_master) begin
      if (size_hi) begin
        frame_last = AFSP_LAST_128;
        my_slot = {1'b0, slot_lo};
      end else begin
        alt_sync = slot_lo;
      end
    end else begin
      case ({strap_q[0], strap_q[1]})
        2'b00: frame_last = AFSP_LAST_64;
        2'b01: begin
          frame_last = AFSP_LAST_128;
          my_slot = {1'b0, slot_lo};
        end
        2'b10: begin
          frame_last = AFSP_LAST_256;
          my_slot = {size_hi, slot_lo};
        end
        2'b11: begin
          frame_last = AFSP_LAST_256;
          my_slot = {size_hi, slot_lo};
          bclk_is_mclk = 1'b1;
        end
        default: frame_last = AFSP_LAST_64;
      endcase
    end
  end

  // ==========================================================
  // bit timing and framing state
  // ==========================================================
  afsp_link_e st_q, st_d;
  logic [7:0] div_q, div_d;            // master clocks into the current bit
  logic [7:0] bit_q, bit_d;            // bit index within frame
  logic bclk_q, bclk_d;                // driven bit clock
  logic fs_q, fs_d;                    // driven frame sync
  logic bin_q, sync_seen_q, sync_seen_d;
  logic armed_q, armed_d;              // a whole frame start has been seen
  logic [7:0] period, half;
  logic samp_tick, adv_tick;
  logic [7:0] bit_next;

  assign period = afsp_bit_period(rate, size_hi);
  assign half = period >> 1;

  // one process decides when bits are sampled and advanced in both roles
  always_comb begin
    if (is_master) begin
      // edges come from the same divider as the sample clock, never free-running
      samp_tick = (st_q == AFSP_LS_RUN) && (div_q == half);
      adv_tick = (st_q == AFSP_LS_RUN) && (div_q == period - 8'h01);
    end else begin
      samp_tick = (st_q != AFSP_LS_RESET) && bin_q && !BIT_CLOCK_IN;
      adv_tick = (st_q != AFSP_LS_RESET) && !bin_q && BIT_CLOCK_IN;
    end
    bit_next = (bit_q == frame_last) ? 8'h00 : bit_q + 8'h01;
  end

  // next-state of the framer
  always_comb begin
    st_d = st_q;
    div_d = div_q;
    bit_d = bit_q;
    bclk_d = bclk_q;
    fs_d = fs_q;
    sync_seen_d = sync_seen_q;
    case (st_q)
      AFSP_LS_RESET: begin
        if (mode_dsp) begin
          st_d = is_master ? AFSP_LS_RUN : AFSP_LS_HUNT;
          bit_d = is_master ? frame_last : 8'h00;
          fs_d = is_master && !alt_sync;
          bclk_d = is_master;
        end
      end
      AFSP_LS_HUNT, AFSP_LS_RUN: begin
        if (is_master) begin
          div_d = adv_tick ? 8'h00 : div_q + 8'h01;
          // fall one cycle early so that a two-cycle bit still has a low phase
          if (div_q == half - 8'h01) begin
            bclk_d = 1'b0;
          end
          if (adv_tick) begin
            bclk_d = 1'b1;
            bit_d = bit_next;
            fs_d = alt_sync ? (bit_next <= AFSP_LR_LAST) : (bit_next == frame_last);
          end
        end else begin
          if (samp_tick && FRAME_SYNC_IN) begin
            sync_seen_d = 1'b1;
          end
          if (adv_tick) begin
            sync_seen_d = 1'b0;
            if (sync_seen_q) begin
              bit_d = 8'h00;
              st_d = AFSP_LS_RUN;
            end else begin
              bit_d = bit_next;
            end
          end
        end
        if (POWER_DOWN) begin
          st_d = AFSP_LS_OFF;
        end
      end
      AFSP_LS_OFF: begin
        if (!POWER_DOWN) begin
          st_d = AFSP_LS_RESET;
          div_d = 8'h00;
        end
      end
      default: st_d = AFSP_LS_RESET;
    endcase
    // the bit caught at start-up is not a whole sub-frame: wait for bit 0
    armed_d = (st_d == AFSP_LS_RUN) && (armed_q || (adv_tick && bit_d == 8'h00));
  end

  // framer registers
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      st_q <= AFSP_LS_RESET;
      div_q <= 8'h00;
      bit_q <= 8'h00;
      bclk_q <= 1'b0;
      fs_q <= 1'b0;
      bin_q <= 1'b0;
      sync_seen_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (CE) begin
      st_q <= st_d;
      div_q <= div_d;
      bit_q <= bit_d;
      bclk_q <= bclk_d;
      fs_q <= fs_d;
      bin_q <= BIT_CLOCK_IN;
      sync_seen_q <= sync_seen_d;
      armed_q <= armed_d;
    end
  end

  // master drives in reset (low), floats in power down
  assign BIT_CLOCK_OUT = bclk_q;
  assign FRAME_SYNC_OUT = fs_q;
  assign BIT_CLOCK_OE = mode_dsp && is_master && !POWER_DOWN;
  assign FRAME_SYNC_OE = mode_dsp && is_master && !POWER_DOWN;

  // ==========================================================
  // receive shift, controls and buffer
  // ==========================================================
  afsp_stream_if wr_if ();
  afsp_stream_if rd_if ();
  logic [AFSP_WORD_W-1:0] sh_q, sh_d;  // incoming sub-frame
  logic [AFSP_ATT_W-1:0] attl_q, attl_d, attr_q, attr_d;
  logic gpo_q, gpo_d, ovr_q, ovr_d, push_q, push_d;
  logic [AFSP_WORD_W-1:0] word_q, word_d;
  logic in_slot;

  // capture only our sub-frame; a word is offered for one cycle
  always_comb begin
    in_slot = (st_q == AFSP_LS_RUN) && armed_q && (bit_q[7:6] == my_slot);
    sh_d = sh_q;
    attl_d = attl_q;
    attr_d = attr_q;
    gpo_d = gpo_q;
    word_d = word_q;
    push_d = 1'b0;
    ovr_d = ovr_q || (push_q && !wr_if.ready); // buffer full and receiver stalled
    if (samp_tick && in_slot) begin
      sh_d = {sh_q[AFSP_WORD_W-2:0], SERIAL_DATA_IN};
      if (bit_q[5:0] == AFSP_SUB_LAST) begin
        push_d = 1'b1;
        word_d = sh_d;
        attl_d = sh_d[AFSP_ATT_L_MSB -: AFSP_ATT_W];
        attr_d = sh_d[AFSP_ATT_R_MSB -: AFSP_ATT_W];
        gpo_d = sh_d[AFSP_GPO_BIT];
      end
    end
  end

  // receive registers
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      sh_q <= '0;
      word_q <= '0;
      attl_q <= AFSP_ATT_RST;
      attr_q <= AFSP_ATT_RST;
      gpo_q <= 1'b0;
      ovr_q <= 1'b0;
      push_q <= 1'b0;
    end else if (CE) begin
      sh_q <= sh_d;
      word_q <= word_d;
      attl_q <= attl_d;
      attr_q <= attr_d;
      gpo_q <= gpo_d;
      ovr_q <= ovr_d;
      push_q <= push_d;
    end
  end

  assign wr_if.valid = push_q;
  assign wr_if.data = word_q;
  assign rd_if.ready = WORD_READY;
  assign WORD_VALID = rd_if.valid;
  assign WORD_DATA = rd_if.data;
  assign WORD_OVERRUN = ovr_q;
  assign ATTEN_LEFT = attl_q;
  assign ATTEN_RIGHT = attr_q;
  assign GP_OUTPUT_PIN = mode_dsp && gpo_q;

  afsp_buf2 u_buf (
    .clock(CLOCK),
    .rst_b(RST_B),
    .ce(CE),
    .wr(wr_if.snk),
    .rd(rd_if.src)
  );

  // ==========================================================
  // rate sensing and general purpose inputs
  // ==========================================================
  logic [7:0] ratio_cnt_q, ratio_cnt_d, ratio_q, ratio_d;
  logic [1:0] gpi_q, gpi_d;
  logic [11:0] div_sel;

  // master clocks between two rising bit clock edges give the ratio
  always_comb begin
    ratio_cnt_d = adv_tick ? 8'h01 : ratio_cnt_q + 8'h01;
    ratio_d = (!is_master && adv_tick) ? ratio_cnt_q : ratio_q;
    gpi_d = {GP_INPUT_PIN, !is_master && RATE_STRAP_C};
    if (is_master) begin
      div_sel = afsp_rate_n(rate);
    end else if (bclk_is_mclk) begin
      div_sel = AFSP_MCLK_FS;
    end else begin
      div_sel = 12'({4'h0, ratio_q} * ({4'h0, frame_last} + 12'h001));
    end
  end

  // sensing registers
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      ratio_cnt_q <= 8'h00;
      ratio_q <= 8'h00;
      gpi_q <= 2'h0;
    end else if (CE) begin
      ratio_cnt_q <= ratio_cnt_d;
      ratio_q <= ratio_d;
      gpi_q <= gpi_d;
    end
  end

  assign SAMPLE_DIVIDER = div_sel;
  assign GP_INPUT_STATE = gpi_q;
  assign DSP_SERIAL_MODE = mode_dsp;
  assign SPLIT_CONTROL_MODE = mode_split;

  // ==========================================================
  // split-mode interrupt
  // ==========================================================
  logic irq_low;

  afsp_irq u_irq (
    .clock(CLOCK),
    .rst_b(RST_B),
    .ce(CE),
    .enable(mode_split),
    .conv_valid(CONVERTER_VALID_FLAG),
    .first_di(FIRST_DIGITAL_INPUT),
    .left_clip(LEFT_CLIP_FLAG),
    .right_clip(RIGHT_CLIP_FLAG),
    .err_code(BIT_CLOCK_ERROR),
    .mask_bit(INTERRUPT_MASK_BIT),
    .ctrl_read(CONTROL_PORT_READ),
    .pending(INTERRUPT_PENDING),
    .pin_low(irq_low)
  );

  // open collector: only ever pulls low
  assign INTERRUPT_OUT_PIN_OUT = 1'b0;
  assign INTERRUPT_OUT_PIN_OE = irq_low;

  // ==========================================================
  // checks
  // ==========================================================
  a_pins_float_pd: assert property (@(posedge CLOCK) disable iff (!RST_B)
    POWER_DOWN |-> !BIT_CLOCK_OE && !FRAME_SYNC_OE)
    else $error("master pins driven in power down");
  a_pins_slave_in: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !is_master |-> !BIT_CLOCK_OE && !FRAME_SYNC_OE)
    else $error("slave drives link pins");
  a_sync_pulse_pos: assert property (@(posedge CLOCK) disable iff (!RST_B)
    is_master && !alt_sync && st_q == AFSP_LS_RUN |-> fs_q == (bit_q == frame_last))
    else $error("sync pulse not in bit before data");
  a_sync_alt_word: assert property (@(posedge CLOCK) disable iff (!RST_B)
    is_master && alt_sync && st_q == AFSP_LS_RUN |-> fs_q == (bit_q <= AFSP_LR_LAST))
    else $error("alt sync not high for left word");
  a_frame_wrap: assert property (@(posedge CLOCK) disable iff (!RST_B)
    CE && adv_tick && is_master && bit_q == frame_last |=> bit_q == 8'h00)
    else $error("master frame length wrong");
  a_atten_field: assert property (@(posedge CLOCK) disable iff (!RST_B)
    CE && push_d |=> attl_q == $past(sh_d[13:9]) && attr_q == $past(sh_d[8:4]))
    else $error("attenuation bits misplaced");
  a_master_rate: assert property (@(posedge CLOCK) disable iff (!RST_B)
    is_master |-> SAMPLE_DIVIDER == afsp_rate_n(rate))
    else $error("master divider does not follow rate straps");
  c_master_word: cover property (@(posedge CLOCK) disable iff (!RST_B)
    is_master && push_q);
  c_slave_word: cover property (@(posedge CLOCK) disable iff (!RST_B)
    !is_master && push_q);
  c_buffer_full: cover property (@(posedge CLOCK) disable iff (!RST_B)
    !wr_if.ready);
endmodule // afsp_framer

// ==== verification/afsp_dsp_model.sv ====
// partner: dsp that shifts a word into the codec on the shared link bit clock
`timescale 1ns/10ps
module afsp_dsp_model (
  // link
  input wire logic clock,
  input wire logic bclk,
  input wire logic fsync,
  input wire logic [63:0] word,
  output logic sdata
);
  logic b_q; // last bit clock
  logic f_q; // sync seen in this bit
  logic [6:0] i_q; // bit index in frame
  logic [6:0] j; // next index
  initial sdata = 1'b0;
  // new bit on each rise; second half of a long frame carries the inverse
  always @(posedge clock) begin
    b_q <= bclk;
    if (bclk && !b_q) begin
      j = f_q ? 7'h00 : i_q + 7'h01;
      i_q <= j;
      sdata <= word[~j[5:0]] ^ j[6];
      f_q <= fsync;
    end
  end
endmodule // afsp_dsp_model

// ==== verification/tb_afsp_framer.sv ====
// testbench: master framing, rates, buffer, power down, slave, interrupt
`timescale 1ns/10ps
module tb_afsp_framer;
  localparam logic [63:0] W = 64'hA5C30F961E2DB487; // sent word
  logic CLOCK, RST_B = 1'b0, CE = 1'b1, POWER_DOWN = 1'b0, MASTER_SELECT_STRAP = 1'b1;
  logic FRAME_SIZE_STRAP_HI = 1'b0, SLOT_SELECT_STRAP_LO = 1'b0, GP_INPUT_PIN = 1'b0;
  logic WORD_READY = 1'b0, CONVERTER_VALID_FLAG = 1'b0, FIRST_DIGITAL_INPUT = 1'b0;
  logic INTERRUPT_MASK_BIT = 1'b0, CONTROL_PORT_READ = 1'b0, BIT_CLOCK_IN = 1'b0;
  logic FRAME_SYNC_IN = 1'b0, LEFT_CLIP_FLAG = 1'b0, RIGHT_CLIP_FLAG = 1'b0;
  logic [3:0] BIT_CLOCK_ERROR = 4'h0;
  logic [2:0] md = 3'h2, rt = 3'h0; // mode and rate straps
  wire MODE_STRAP_THREE = md[2], MODE_STRAP_TWO = md[1], MODE_STRAP_ONE = md[0];
  wire RATE_STRAP_A = rt[2], RATE_STRAP_B = rt[1], RATE_STRAP_C = rt[0];
  wire SERIAL_DATA_IN;
  logic BIT_CLOCK_OUT, BIT_CLOCK_OE, FRAME_SYNC_OUT, FRAME_SYNC_OE, GP_OUTPUT_PIN;
  logic WORD_VALID, WORD_OVERRUN, DSP_SERIAL_MODE, SPLIT_CONTROL_MODE;
  logic INTERRUPT_OUT_PIN_OUT, INTERRUPT_OUT_PIN_OE, INTERRUPT_PENDING;
  logic [1:0] GP_INPUT_STATE;
  logic [63:0] WORD_DATA;
  logic [4:0] ATTEN_LEFT, ATTEN_RIGHT;
  logic [11:0] SAMPLE_DIVIDER;
  int n_fail = 0, checks = 0, hi, tot;
  logic [11:0] nt [8] = '{12'h100, 12'h180, 12'h200, 12'h280, 12'h300, 12'h400, 12'h500, 12'h600};
  logic [1:0] fm [3] = '{2'b00, 2'b01, 2'b11}; // size, slot straps
  afsp_framer dut (.*);
  // the model sees the shared pins: driven by the codec as master, by the bench as slave
  afsp_dsp_model pm (.clock(CLOCK), .bclk(BIT_CLOCK_OE ? BIT_CLOCK_OUT : BIT_CLOCK_IN),
    .fsync(FRAME_SYNC_OE ? FRAME_SYNC_OUT : FRAME_SYNC_IN), .word(W), .sdata(SERIAL_DATA_IN));
  // ==========================================================
  // helpers
  // ==========================================================
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // straps are only taken while reset is low
  task automatic rst(input logic [2:0] m, input logic [2:0] r, input logic ma);
    md = m;
    rt = r;
    MASTER_SELECT_STRAP = ma;
    RST_B = 1'b0;
    cyc(8);
    chk({FRAME_SYNC_OUT, BIT_CLOCK_OUT}, 2'b00);
    RST_B = 1'b1;
  endtask
  // take one word; ready is held until the accepting edge
  task automatic get(input logic [63:0] e);
    for (int k = 0; k < 600 && WORD_VALID !== 1'b1; k++) cyc(1);
    chk(WORD_DATA, e);
    WORD_READY = 1'b1;
    cyc(1);
    WORD_READY = 1'b0;
    cyc(1);
  endtask
  // bit clock rises from one sync rise to the next, and those with sync high
  task automatic frm();
    logic c, f;
    int k;
    hi = 0;
    tot = 0;
    k = 0;
    while (FRAME_SYNC_OUT !== 1'b0 && k < 3000) begin cyc(1); k++; end
    while (FRAME_SYNC_OUT !== 1'b1 && k < 3000) begin cyc(1); k++; end
    c = 1'b1;
    f = 1'b1;
    while (k < 3000 && !(FRAME_SYNC_OUT && !f)) begin
      f = FRAME_SYNC_OUT;
      cyc(1);
      k++;
      if (BIT_CLOCK_OUT && !c) begin tot++; hi += FRAME_SYNC_OUT; end
      c = BIT_CLOCK_OUT;
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog well past the few thousand cycles the tests need
  initial begin
    cyc(20000);
    n_fail++;
    give_verdict();
  end
  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    for (int r = 0; r < 8; r++) begin // new rate needs a reset
      rst(3'h2, r[2:0], 1'b1);
      chk(SAMPLE_DIVIDER, nt[r]);
      chk({DSP_SERIAL_MODE, BIT_CLOCK_OE, FRAME_SYNC_OE}, 3'h7);
      cyc(1);
    end
    for (int m = 0; m < 3; m++) begin
      {FRAME_SIZE_STRAP_HI, SLOT_SELECT_STRAP_LO} = fm[m];
      rst(3'h2, 3'h0, 1'b1);
      frm();
      chk(hi, m == 1 ? 32 : 1);
      chk(tot, m == 2 ? 128 : 64);
      if (m != 1) get(m == 2 ? ~W : W);
      if (m == 0) chk({ATTEN_LEFT, ATTEN_RIGHT, GP_OUTPUT_PIN}, {W[13:4], W[2]});
    end
    {FRAME_SIZE_STRAP_HI, SLOT_SELECT_STRAP_LO} = 2'b00;
    rst(3'h2, 3'h0, 1'b1);
    cyc(900); // three words offered, receiver stalled
    chk(WORD_OVERRUN, 1'b1);
    get(W);
    get(W);
    chk(WORD_VALID, 1'b0);
    POWER_DOWN = 1'b1;
    cyc(2);
    chk({BIT_CLOCK_OE, FRAME_SYNC_OE}, 2'b00);
    POWER_DOWN = 1'b0;
    GP_INPUT_PIN = 1'b1;
    rst(3'h2, 3'h1, 1'b0);
    cyc(2);
    chk({BIT_CLOCK_OE, FRAME_SYNC_OE, GP_INPUT_STATE}, 4'h3);
    // slave 64-bit frames, bit clock of four cycles, sync high in the last bit
    for (int b = 0; b < 128; b++) begin
      FRAME_SYNC_IN = (b[5:0] == 6'h3F);
      BIT_CLOCK_IN = 1'b1;
      cyc(2);
      BIT_CLOCK_IN = 1'b0;
      cyc(2);
    end
    FRAME_SYNC_IN = 1'b0;
    get(W);
    chk(SAMPLE_DIVIDER, 12'h100);
    rst(3'h4, 3'h0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) BIT_CLOCK_ERROR = 4'h3;
      cyc(2);
      {LEFT_CLIP_FLAG, FIRST_DIGITAL_INPUT, CONVERTER_VALID_FLAG} = 3'h1 << k;
      if (k == 3) BIT_CLOCK_ERROR = 4'h0;
      cyc(2);
      chk({SPLIT_CONTROL_MODE, INTERRUPT_PENDING, INTERRUPT_OUT_PIN_OE, INTERRUPT_OUT_PIN_OUT},
        4'hE);
      INTERRUPT_MASK_BIT = 1'b1;
      cyc(1);
      chk({INTERRUPT_PENDING, INTERRUPT_OUT_PIN_OE}, 2'b10);
      INTERRUPT_MASK_BIT = 1'b0;
      CONTROL_PORT_READ = 1'b1;
      cyc(1);
      CONTROL_PORT_READ = 1'b0;
      cyc(1);
      chk(INTERRUPT_PENDING, 1'b0);
    end
    give_verdict();
  end
endmodule // tb_afsp_framer
